// >>> hw/acc_channel.sv
`timescale 1ns/1ps
// Sequencer of one comparator: start-up wait, single or continuous sampling.
module acc_channel #(parameter int CW = 8) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    acc_chan_if.chan  ch
);
    import acc_pkg::*;

    acc_state_type st_q;
    logic [CW-1:0] cnt_q;
    logic          active;
    logic          take;

    assign active = ch.mod_en & ch.cfg.en;
    assign take = (st_q == ACC_LIVE) || (st_q == ACC_WARM && cnt_q == '0);
    assign ch.busy = (st_q == ACC_WARM);
    assign ch.on = (st_q != ACC_OFF);

    // Dropping either enable parks the channel; its own bit is untouched.
    always_ff @(posedge clk_in) begin
        if (rst_in || !active) begin
            st_q <= ACC_OFF;
        end else begin
            case (st_q)
                ACC_OFF:  if (!ch.cfg.single || ch.start) st_q <= ACC_WARM;
                ACC_WARM: if (cnt_q == '0) begin
                    st_q <= ch.cfg.single ? ACC_OFF : ACC_LIVE;
                end
                ACC_LIVE: st_q <= ACC_LIVE;
                default:  st_q <= ACC_OFF;
            endcase
        end
    end

    // Start-up wait is reloaded whenever the channel rests.
    always_ff @(posedge clk_in) begin
        if (rst_in || st_q == ACC_OFF) begin
            cnt_q <= ch.startup;
        end else if (st_q == ACC_WARM && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // One sample per clock in continuous mode, one per start otherwise.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ch.result <= 1'b0;
            ch.prev   <= 1'b0;
            ch.done   <= 1'b0;
        end else begin
            ch.done <= take;
            if (take) begin
                ch.result <= ch.cmp_raw;
                ch.prev   <= ch.result;
            end
        end
    end

    // A finished sample outranks a start in the same cycle.
    always_ff @(posedge clk_in) begin
        if (rst_in || !active) begin
            ch.ready <= 1'b0;
        end else if (take) begin
            ch.ready <= 1'b1;
        end else if (ch.start && st_q == ACC_OFF) begin
            ch.ready <= 1'b0;
        end
    end
endmodule

// >>> hw/acc_edge.sv
`timescale 1ns/1ps
// Picks the interrupt condition of one comparator from its last two samples.
module acc_edge (
    input  wire acc_pkg::acc_isel_type sel_in,
    input  wire logic                  cur_in,
    input  wire logic                  prev_in,
    input  wire logic                  done_in,
    output logic                       hit_out
);
    import acc_pkg::*;

    // Edges compare the newest sample with the one before it.
    always_comb begin
        case (sel_in)
            ACC_IS_TOGGLE: hit_out = done_in & (cur_in ^ prev_in);
            ACC_IS_RISE:   hit_out = done_in & cur_in & ~prev_in;
            ACC_IS_FALL:   hit_out = done_in & ~cur_in & prev_in;
            ACC_IS_EOC:    hit_out = done_in;
            default:       hit_out = 1'b0;
        endcase
    end
endmodule

// >>> hw/acc_top.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "acc_regs.svh"
// Contract
// - A result is one when the positive input exceeds the negative.
// - Event setup must precede enable and is frozen while enabled.
// - Comparator setup must precede its enable and is then frozen.
// - A comparator runs only with module and own enable both set.
// - Module disable stops comparators but keeps their own enables.
// - Soft reset clears all but debug control and disables the module.
// - Result withheld for start-up after enable; continuous only first.
// - Doubler-off bit stops the doubler; use only above 2.5V supply.
// - Interrupt condition: toggle, rise, fall or end of comparison.
// - Event outputs follow the result regardless of interrupt enable.
// - Continuous mode compares until disabled, updating state and ready.
// - Edges compare current and previous samples at the sampling rate.
// - Sleeping continuous toggle requests clock, released unless wake.
// - Single mode idles until a start write, then compares once.
// - Start clears ready; hardware sets it when the comparison ends.
// - Trigger read starts single channels and stalls until all ready.
// - Enabled input event starts its own channel and clears ready.
// - Sleep event start requests clock, then releases unless wake.
// - Keeps working in sleep while its clock runs; irq may wake.
// - Keeps running while the processor is halted for debug.
// - Writes are guardable except command and flags; debugger exempt.
// - Certain writes cross a synchronising stage before taking effect.
// - One flag per comparator and one for window, each maskable.
module acc_top #(parameter int CW = 8) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic [1:0]  cmp_gt_in,
    input  wire logic [1:0]  event_trig_in,
    input  wire logic        sleep_in,
    input  wire logic        write_guard_in,
    input  wire logic        debugger_in,
    output logic [1:0]       comp_enable_out,
    output logic             doubler_on_out,
    output logic [1:0]       event_out,
    output logic             win_event_out,
    output logic             clk_req_out,
    output logic             irq_out
);
    import acc_pkg::*;

    logic          mod_en_q, en_pend_q, dbl_off_q, wake_q, soft_reset_bit_q;
    logic          dbgrun_q, bvalid_q, rvalid_q, rd_wait_q, win_q;
    logic [1:0]    bresp_q, rresp_q, ev_q;
    logic [5:0]    evcfg_q;
    logic [2:0]    irq_en_q, irq_flag_q, irq_set;
    logic [CW-1:0] startup_q;
    logic [31:0]   rdata_q, rd_d, wd;
    logic          rd_err, aw_go, ar_go, wr_ok, wr_err, wr_map, guarded;
    logic          rst_any, trig_go, all_rdy, trig_hold_q;
    logic [1:0]    start, res, prv, rdy, busy, on, done, hit, enabled;
    acc_cfg_type   cfg_q [2];

    // Byte-lane merge used by the flag, interrupt-enable, comparator setup and start-up writes.
    function automatic logic [31:0] acc_wmerge(input logic [31:0] o,
                                               input logic [31:0] n,
                                               input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Channels.

    acc_chan_if #(.CW(CW)) ch [2] ();

    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign ch[i].cfg = cfg_q[i];
        assign ch[i].mod_en = mod_en_q;
        assign ch[i].start = start[i];
        assign ch[i].startup = startup_q;
        assign ch[i].cmp_raw = cmp_gt_in[i];
        assign res[i] = ch[i].result;
        assign prv[i] = ch[i].prev;
        assign rdy[i] = ch[i].ready;
        assign busy[i] = ch[i].busy;
        assign on[i] = ch[i].on;
        assign done[i] = ch[i].done;
        assign enabled[i] = mod_en_q & cfg_q[i].en;
        // Starts from command write, trigger read or input event.
        assign start[i] = cfg_q[i].single & (
            (aw_go && s_axi_awaddr_in == `ACC_A_CMD &&
             s_axi_wstrb_in[0] && s_axi_wdata_in[i]) ||
            (evcfg_q[i] && event_trig_in[i]) ||
            (trig_go && !busy[i]));
        acc_channel #(.CW(CW)) u_chan (
            .clk_in (ref_clk_in),
            .rst_in (rst_any),
            .ch     (ch[i])
        );
        acc_edge u_edge (
            .sel_in  (cfg_q[i].irqsel),
            .cur_in  (res[i]),
            .prev_in (prv[i]),
            .done_in (done[i]),
            .hit_out (hit[i])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Register bus.

    // Soft reset acts one cycle after its write and spares debug control.
    assign rst_any = rst_in | soft_reset_bit_q;
    assign aw_go = s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_q;
    assign ar_go = s_axi_arvalid_in & ~rvalid_q & ~rd_wait_q;
    assign s_axi_awready_out = aw_go;
    assign s_axi_wready_out = aw_go;
    assign s_axi_arready_out = ar_go;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;

    // Command and flag writes bypass the guard; a debugger bypasses it all.
    assign guarded = s_axi_awaddr_in != `ACC_A_CMD &&
                     s_axi_awaddr_in != `ACC_A_IFLAG;
    assign wr_map = s_axi_awaddr_in <= `ACC_A_DBG &&
                    s_axi_awaddr_in[1:0] == 2'h0 &&
                    s_axi_awaddr_in != `ACC_A_STAT &&
                    s_axi_awaddr_in != `ACC_A_TRIG;
    assign wr_err = !wr_map ||
                    (guarded && write_guard_in && !debugger_in);
    assign wr_ok = aw_go & ~wr_err;
    assign wd = acc_wmerge(32'h0000_0000, s_axi_wdata_in, s_axi_wstrb_in);

    // Write response; every write answers the cycle after it is taken.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `ACC_RESP_OK;
        end else if (aw_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_err ? `ACC_RESP_ERR : `ACC_RESP_OK;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // Module control; enable lands one stage late as a clock crossing would.
    always_ff @(posedge ref_clk_in) begin
        if (rst_any) begin
            en_pend_q <= 1'b0;
            mod_en_q  <= 1'b0;
            dbl_off_q <= 1'b0;
            wake_q    <= 1'b0;
        end else begin
            mod_en_q <= en_pend_q;
            if (wr_ok && s_axi_awaddr_in == `ACC_A_CTRL &&
                s_axi_wstrb_in[0]) begin
                en_pend_q <= s_axi_wdata_in[`ACC_B_EN];
                dbl_off_q <= s_axi_wdata_in[`ACC_B_DBLOFF];
                wake_q    <= s_axi_wdata_in[`ACC_B_WAKE];
            end
        end
    end

    // Soft reset pulse.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || soft_reset_bit_q) begin
            soft_reset_bit_q <= 1'b0;
        end else begin
            soft_reset_bit_q <= wr_ok && s_axi_awaddr_in == `ACC_A_CTRL &&
                       s_axi_wstrb_in[0] &&
                       s_axi_wdata_in[`ACC_B_SOFT_RESET_BIT];
        end
    end

    // Debug control survives soft reset; the block never halts for debug.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            dbgrun_q <= 1'b0;
        end else if (wr_ok && s_axi_awaddr_in == `ACC_A_DBG &&
                     s_axi_wstrb_in[0]) begin
            dbgrun_q <= s_axi_wdata_in[0];
        end
    end

    // Event setup and start-up count, frozen while the module runs.
    always_ff @(posedge ref_clk_in) begin
        if (rst_any) begin
            evcfg_q   <= '0;
            startup_q <= CW'(`ACC_STARTUP_RST);
        end else if (wr_ok && !mod_en_q && !en_pend_q) begin
            if (s_axi_awaddr_in == `ACC_A_EVCFG && s_axi_wstrb_in[0]) begin
                evcfg_q <= s_axi_wdata_in[5:0];
            end
            if (s_axi_awaddr_in == `ACC_A_START) begin
                startup_q <= CW'(acc_wmerge(32'(startup_q), s_axi_wdata_in,
                                            s_axi_wstrb_in));
            end
        end
    end

    // Comparator setup; only the enable bit moves while enabled.
    always_ff @(posedge ref_clk_in) begin
        if (rst_any) begin
            cfg_q[0] <= '0;
            cfg_q[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_ok && s_axi_awaddr_in ==
                    (i == 0 ? `ACC_A_CFG0 : `ACC_A_CFG1)) begin
                    if (cfg_q[i].en) begin
                        cfg_q[i].en <= acc_wmerge(32'(cfg_q[i]), wd,
                                       s_axi_wstrb_in) != 32'h0 ?
                                       s_axi_wstrb_in[0] ?
                                       s_axi_wdata_in[0] : 1'b1 : 1'b0;
                    end else begin
                        cfg_q[i] <= acc_cfg_type'(acc_wmerge(32'(cfg_q[i]),
                                    s_axi_wdata_in, s_axi_wstrb_in) >> 0);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags, events and clock request.

    // Window state: inside when the two comparators disagree.
    assign irq_set = {(res[0] ^ res[1]) != win_q, hit};

    // Flags are cleared by writing one; a set in the same cycle wins.
    always_ff @(posedge ref_clk_in) begin
        if (rst_any) begin
            irq_flag_q <= '0;
            irq_en_q   <= '0;
            win_q      <= 1'b0;
            ev_q       <= '0;
        end else begin
            win_q <= res[0] ^ res[1];
            ev_q  <= res & evcfg_q[`ACC_E_OUT +: 2];
            irq_flag_q <= (irq_flag_q &
                ~((aw_go && s_axi_awaddr_in == `ACC_A_IFLAG) ?
                  wd[2:0] : 3'h0)) | irq_set;
            if (wr_ok && s_axi_awaddr_in == `ACC_A_IENSET) begin
                irq_en_q <= irq_en_q | wd[2:0];
            end else if (wr_ok && s_axi_awaddr_in == `ACC_A_IENCLR) begin
                irq_en_q <= irq_en_q & ~wd[2:0];
            end
        end
    end

    assign irq_out = |(irq_flag_q & irq_en_q);
    assign event_out = ev_q;
    assign win_event_out = win_q;
    assign comp_enable_out = on;
    assign doubler_on_out = |on & ~dbl_off_q;
    // In sleep the clock is held only for pending work or a wake-up.
    assign clk_req_out = sleep_in & (|busy |
                         |(on & ~busy & (cmp_gt_in ^ res)) |
                         (wake_q & irq_out));

    ////////////////////////////////////////////////////////////////////
    // Read path, including the stalling trigger read.

    assign trig_go = ar_go && s_axi_araddr_in == `ACC_A_TRIG;
    assign all_rdy = &(rdy | ~enabled);

    always_comb begin
        rd_d   = '0;
        rd_err = 1'b0;
        case (s_axi_araddr_in)
            `ACC_A_CTRL: begin
                rd_d[`ACC_B_EN]     = en_pend_q;
                rd_d[`ACC_B_DBLOFF] = dbl_off_q;
                rd_d[`ACC_B_WAKE]   = wake_q;
            end
            `ACC_A_CMD:    rd_d = '0;
            `ACC_A_EVCFG:  rd_d[5:0] = evcfg_q;
            `ACC_A_IENCLR: rd_d[2:0] = irq_en_q;
            `ACC_A_IENSET: rd_d[2:0] = irq_en_q;
            `ACC_A_IFLAG:  rd_d[2:0] = irq_flag_q;
            `ACC_A_STAT: begin
                rd_d[1:0]               = res;
                rd_d[`ACC_S_WIN]        = win_q;
                rd_d[`ACC_S_RDY +: 2]   = rdy;
                rd_d[`ACC_S_SYNC]       = en_pend_q ^ mod_en_q;
            end
            `ACC_A_CFG0:   rd_d[14:0] = cfg_q[0];
            `ACC_A_CFG1:   rd_d[14:0] = cfg_q[1];
            `ACC_A_START:  rd_d[CW-1:0] = startup_q;
            `ACC_A_DBG:    rd_d[0] = dbgrun_q;
            default:       rd_err = 1'b1;
        endcase
    end

    // Ready of a channel started by the trigger read drops at the edge that takes the read,
    // yet the first waiting cycle still ignores the ready bits.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            trig_hold_q <= 1'b0;
        end else begin
            trig_hold_q <= trig_go;
        end
    end

    // The trigger read answers only once every enabled channel is ready.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rvalid_q  <= 1'b0;
            rd_wait_q <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= `ACC_RESP_OK;
        end else if (trig_go) begin
            rd_wait_q <= 1'b1;
        end else if (rd_wait_q) begin
            if (all_rdy && !trig_hold_q) begin
                rd_wait_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= {26'h0, rdy, 2'h0, res};
                rresp_q   <= `ACC_RESP_OK;
            end
        end else if (ar_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_d;
            rresp_q  <= rd_err ? `ACC_RESP_ERR : `ACC_RESP_OK;
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in || soft_reset_bit_q);

    property p_result;
        done[0] |-> res[0] == $past(cmp_gt_in[0]);
    endproperty
    a_result: assert property (p_result)
        else $error("result does not match sampled input");

    property p_evlock;
        mod_en_q && en_pend_q |=> $stable(evcfg_q);
    endproperty
    a_evlock: assert property (p_evlock)
        else $error("event setup changed while enabled");

    property p_cfglock;
        cfg_q[0].en && $past(cfg_q[0].en) |->
            cfg_q[0][14:1] == $past(cfg_q[0][14:1]);
    endproperty
    a_cfglock: assert property (p_cfglock)
        else $error("comparator setup changed while enabled");

    property p_run_needs_both;
        on[0] |-> $past(mod_en_q) && $past(cfg_q[0].en);
    endproperty
    a_run_needs_both: assert property (p_run_needs_both)
        else $error("comparator ran without both enables");

    property p_soft_reset_bit;
        soft_reset_bit_q ##1 1'b1 |-> !mod_en_q && evcfg_q == 6'h00;
    endproperty
    a_soft_reset_bit: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        p_soft_reset_bit)
        else $error("soft reset left the module enabled");

    property p_startup;
        $rose(busy[0]) |-> !rdy[0] [*2];
    endproperty
    a_startup: assert property (p_startup)
        else $error("ready shown during start-up");

    property p_start_clears;
        start[0] && !on[0] && enabled[0] |=> !rdy[0] && busy[0];
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start did not clear ready");

    property p_trig_stall;
        rvalid_q && $rose(rvalid_q) && $past(rd_wait_q) |->
            $past(all_rdy);
    endproperty
    a_trig_stall: assert property (p_trig_stall)
        else $error("trigger read answered before ready");

    property p_trig_hold;
        trig_go |=> !rvalid_q [*2];
    endproperty
    a_trig_hold: assert property (p_trig_hold)
        else $error("trigger read answered with stale ready");

    property p_guard;
        aw_go && write_guard_in && !debugger_in &&
        guarded |=> bresp_q == `ACC_RESP_ERR;
    endproperty
    a_guard: assert property (p_guard)
        else $error("guarded write was accepted");

    property p_flag;
        hit[0] |=> irq_flag_q[0];
    endproperty
    a_flag: assert property (p_flag)
        else $error("interrupt flag missed");

    c_single: cover property (start[0] ##[1:300] done[0]);
    c_trig: cover property (trig_go ##[1:300] rvalid_q);
    c_live: cover property (on[1] && !busy[1] && hit[1]);
    c_sleep: cover property (sleep_in && clk_req_out);
endmodule

// >>> shared/acc_chan_if.sv
`timescale 1ns/1ps
// Control and status of one comparator channel.
interface acc_chan_if #(parameter int CW = 8);
    acc_pkg::acc_cfg_type cfg;
    logic                 mod_en;
    logic                 start;
    logic [CW-1:0]        startup;
    logic                 cmp_raw;
    logic                 result;
    logic                 prev;
    logic                 ready;
    logic                 busy;
    logic                 on;
    logic                 done;
    modport ctl (output cfg, mod_en, start, startup, cmp_raw,
                 input result, prev, ready, busy, on, done);
    modport chan (input cfg, mod_en, start, startup, cmp_raw,
                  output result, prev, ready, busy, on, done);
endinterface

// >>> shared/acc_pkg.sv
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_IS_TOGGLE = 2'h0,
        ACC_IS_RISE   = 2'h1,
        ACC_IS_FALL   = 2'h2,
        ACC_IS_EOC    = 2'h3
    } acc_isel_type;
    typedef enum logic [2:0] {
        ACC_OFF  = 3'h1,
        ACC_WARM = 3'h2,
        ACC_LIVE = 3'h4
    } acc_state_type;
    typedef struct packed {
        logic [1:0]   filter_length_field;
        logic [2:0]   neg_sel;
        logic [2:0]   pos_sel;
        acc_isel_type irqsel;
        logic         hysteresis_bit;
        logic [1:0]   speed;
        logic         single;
        logic         en;
    } acc_cfg_type;
endpackage

// >>> shared/acc_regs.svh
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register byte offsets on the register bus.
`define ACC_A_CTRL      8'h00
`define ACC_A_CMD       8'h04
`define ACC_A_EVCFG     8'h08
`define ACC_A_IENCLR    8'h0C
`define ACC_A_IENSET    8'h10
`define ACC_A_IFLAG     8'h14
`define ACC_A_STAT      8'h18
`define ACC_A_TRIG      8'h1C
`define ACC_A_CFG0      8'h20
`define ACC_A_CFG1      8'h24
`define ACC_A_START     8'h28
`define ACC_A_DBG       8'h2C

// Field positions.
`define ACC_B_SOFT_RESET_BIT     0
`define ACC_B_EN        1
`define ACC_B_DBLOFF    2
`define ACC_B_WAKE      3
`define ACC_E_OUT       4
`define ACC_S_WIN       2
`define ACC_S_RDY       4
`define ACC_S_SYNC      7
`define ACC_F_WIN       2

// Reset values and bus answers.
`define ACC_STARTUP_RST 8'h04
`define ACC_RESP_OK     2'h0
`define ACC_RESP_ERR    2'h2

`endif

// >>> testbench/acc_far_model.sv
`timescale 1ns/1ps
// Event source on the far side: one start pulse per requested cycle.
module acc_far_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] fire_in,
    output logic [1:0]      event_trig_out
);
    // Pulses are registered so they leave just after a clock edge.
    always_ff @(posedge clk_in) begin
        event_trig_out <= fire_in;
    end
endmodule

// >>> testbench/test_analog_comparator_control.sv
`timescale 1ns/1ps
module test_analog_comparator_control;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic slp = 0, grd = 0, dbg = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, v, x;
    logic [1:0] gt = 2'h0, fire = 2'h0, trig, r, br, rr, cen, ev;
    logic awr, wr, bv, arr, rv, irq, cr, dbl, win;
    logic [31:0] rd;
    int errors = 0, checked = 0;
    acc_far_model acc_far_model_inst (.clk_in(clk), .fire_in(fire),
        .event_trig_out(trig));
    acc_top #(.CW(8)) acc_top_inst (.ref_clk_in(clk), .rst_in(rst),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rre), .cmp_gt_in(gt), .event_trig_in(trig),
        .sleep_in(slp), .write_guard_in(grd), .debugger_in(dbg),
        .comp_enable_out(cen), .doubler_on_out(dbl), .event_out(ev),
        .win_event_out(win), .clk_req_out(cr), .irq_out(irq));
    // Clock of 25 ns.
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (e !== g) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Address and data are offered together and held until taken.
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 0; wv <= 0; bre <= 1;
        do @(posedge clk); while (bv !== 1'b1);
        r = br;
        bre <= 0;
    endtask
    task automatic rreg(logic [7:0] a);
        @(posedge clk);
        ara <= a; arv <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0; rre <= 1;
        do @(posedge clk); while (rv !== 1'b1);
        v = rd; r = rr;
        rre <= 0;
    endtask
    // Trigger read word: channel 0 ready and its fresh result.
    function automatic logic [31:0] exp_trig(logic [1:0] g);
        return {26'h0, 2'h1, 3'h0, g[0]};
    endfunction
    // The watchdog allows far more than the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        void'($urandom(65));
        repeat (12) @(posedge clk);
        rst <= 0;
        rreg(8'h28); chk("startup", 32'h4, v);
        rreg(8'h30); chk("unmapped", 32'h2, {30'h0, r});
        wreg(8'h08, 32'h11); wreg(8'h10, 32'h1);
        wreg(8'h20, 32'h63); wreg(8'h00, 32'h2);
        for (int i = 0; i < 4; i++) begin
            x = $urandom;
            gt <= x[1:0];
            wreg(8'h14, 32'h7);
            wreg(8'h04, 32'h1);
            rreg(8'h1C); chk("result", x[0], v[0]);
            chk("ready", 32'h1, v[4]);
            chk("trig", exp_trig(x[1:0]), v);
            chk("irq", 32'h1, irq);
            chk("event", x[0], ev[0]);
            chk("window", x[0], win);
        end
        // A start from the event line drops ready until it completes.
        slp <= 1; fire <= 2'h1; @(posedge clk); fire <= 2'h0;
        repeat (3) @(posedge clk);
        chk("on", 32'h1, cen[0]);
        chk("clkreq", 32'h1, cr);
        chk("doubler", 32'h1, dbl);
        rreg(8'h18); chk("evready", 32'h0, v[4]);
        repeat (12) @(posedge clk);
        chk("clkrel", 32'h0, cr);
        slp <= 0;
        rreg(8'h18); chk("evdone", 32'h1, v[4]);
        wreg(8'h20, 32'h03); rreg(8'h20); chk("cfglock", 32'h63, v);
        wreg(8'h08, 32'h0); rreg(8'h08); chk("evlock", 32'h11, v);
        wreg(8'h00, 32'h0); repeat (4) @(posedge clk);
        chk("off", 32'h0, cen);
        rreg(8'h20); chk("keepen", 32'h1, v[0]);
        grd <= 1; wreg(8'h28, 32'h8); chk("guard", 32'h2, r);
        dbg <= 1; wreg(8'h28, 32'h8); chk("dbgw", 32'h0, r);
        dbg <= 0; wreg(8'h04, 32'h0); chk("cmdw", 32'h0, r);
        grd <= 0; wreg(8'h00, 32'h1); repeat (3) @(posedge clk);
        rreg(8'h20); chk("rstcfg", 32'h0, v);
        rreg(8'h28); chk("rststart", 32'h4, v);
        summarize();
    end
endmodule
